// ---- inc/bpd_params.svh ----
// Offsets, field positions, reset values, response codes and flash trip level of the brownout controller
`ifndef BPD_PARAMS_SVH
`define BPD_PARAMS_SVH
`define BPD_OFS_PWR_CTRL     12'h000
`define BPD_OFS_IRQ_EN0      12'h004
`define BPD_OFS_BO_CFG       12'h008
`define BPD_OFS_USER_CFG1    12'h00c
`define BPD_OFS_RST_SRC      12'h010
`define BPD_OFS_STATUS       12'h014
`define BPD_PWR_MODE_LO_BIT  0
`define BPD_PWR_MODE_HI_BIT  1
`define BPD_BOI_DET_EN_BIT   4
`define BPD_BOI_SRC_EN_BIT   5
`define BPD_GLB_IRQ_EN_BIT   7
`define BPD_BO_LVL_LSB       0
`define BPD_BOR_LVL_LSB      3
`define BPD_BOR_FLAG_BIT     5
`define BPD_BOI_FLAG_BIT     6
`define BPD_POR_FLAG_BIT     4
`define BPD_BO_CFG_RESET     8'h02
`define BPD_USER_CFG1_RESET  8'h10
`define BPD_RESP_OKAY        2'b00
`define BPD_RESP_SLVERR      2'b10
`define BPD_FLASH_TRIP_MV    2400
`endif

// ---- inc/bpd_pkg.sv ----
// Types of the brownout and power-on detect controller
package bpd_pkg;
    typedef enum logic [1:0] {
        BPD_MODE_NORMAL = 2'b00,
        BPD_MODE_IDLE   = 2'b01,
        BPD_MODE_PD     = 2'b10,
        BPD_MODE_TPD    = 2'b11
    } bpd_mode_t;
    typedef enum logic [1:0] {
        BPD_RST_IDLE  = 2'b00,
        BPD_RST_HOLD  = 2'b01,
        BPD_RST_CLEAR = 2'b10
    } bpd_rst_state_t;
endpackage : bpd_pkg

// ---- sim/bpd_supply_model.sv ----
// Behavioural supply comparators with hysteresis facing the brownout controller
`include "bpd_params.svh"
module bpd_supply_model (
    input  var int          vdd_mv,
    input  wire logic [2:0] bor_level_sel,
    input  wire logic [2:0] bo_irq_level_sel,
    output logic            bor_below_fall,
    output logic            bor_above_rise,
    output logic            boi_below_fall,
    output logic            boi_above_rise,
    output logic            flash_below_trip
);
    timeunit 1ns;
    timeprecision 1ns;
    // Reserved codes hold 0 mV, so that comparator can never trip
    localparam int BOR_FALL[8] = '{0, 0, 2250, 2550, 2850, 3150, 3850, 4050};
    localparam int BOR_RISE[8] = '{0, 0, 2400, 2700, 3000, 3300, 4000, 4200};
    localparam int BOI_FALL[8] = '{0, 0, 2550, 2850, 3000, 3450, 4150, 4350};
    localparam int BOI_RISE[8] = '{0, 0, 2700, 3000, 3150, 3600, 4300, 4500};
    // Two thresholds per brownout detector give the hysteresis band; the flash level has one
    assign bor_below_fall   = vdd_mv < BOR_FALL[bor_level_sel];
    assign bor_above_rise   = vdd_mv > BOR_RISE[bor_level_sel];
    assign boi_below_fall   = vdd_mv < BOI_FALL[bo_irq_level_sel];
    assign boi_above_rise   = vdd_mv > BOI_RISE[bo_irq_level_sel];
    assign flash_below_trip = vdd_mv < `BPD_FLASH_TRIP_MV;
endmodule : bpd_supply_model

// ---- sim/testbench.sv ----
// Self-checking bench for the brownout and power-on detect controller
`include "bpd_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 0, aresetn = 0, power_up_evt = 0, flash_op_req = 0;
    logic bbf, bar, ibf, iar, fbt;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] bor_level_sel, bo_irq_level_sel;
    logic bor_en, boi_en, fl_en, chip_reset, brownout_irq, grant, blocked;
    int vdd_mv = 3300;
    int num_errors = 0, tests_run = 0;
    logic [1:0] exp_b[$], exp_rr[$];
    logic [31:0] exp_rd[$], exp_rm[$];
    always #20 aclk = ~aclk;
    bpd_ctrl dut (.aclk(aclk), .aresetn(aresetn), .power_up_evt(power_up_evt),
        .bor_below_fall(bbf), .bor_above_rise(bar), .boi_below_fall(ibf),
        .boi_above_rise(iar), .flash_below_trip(fbt), .flash_op_req(flash_op_req),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .bor_level_sel(bor_level_sel), .bo_irq_level_sel(bo_irq_level_sel),
        .bor_detector_en(bor_en), .boi_detector_en(boi_en), .flash_detector_en(fl_en),
        .chip_reset(chip_reset), .brownout_irq(brownout_irq), .flash_op_grant(grant),
        .flash_op_blocked(blocked));
    bpd_supply_model partner (.vdd_mv(vdd_mv), .bor_level_sel(bor_level_sel),
        .bo_irq_level_sel(bo_irq_level_sel), .bor_below_fall(bbf), .bor_above_rise(bar),
        .boi_below_fall(ibf), .boi_above_rise(iar), .flash_below_trip(fbt));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick
    task automatic setv(input int v);
        @(posedge aclk);
        vdd_mv <= v;
        tick(4);
    endtask : setv
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge aclk);
        exp_b.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (n = 0; n < 50 && !(s_axi_bvalid && s_axi_bready); n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end
        s_axi_bready <= 0;
        if (n == 50) begin
            num_errors++;
            print_verdict();
        end
    endtask : axw
    task automatic axr(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic [1:0] r);
        int n;
        @(posedge aclk);
        exp_rr.push_back(r);
        exp_rd.push_back(d & m);
        exp_rm.push_back(m);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (n = 0; n < 50 && !(s_axi_rvalid && s_axi_rready); n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end
        s_axi_rready <= 0;
        if (n == 50) begin
            num_errors++;
            print_verdict();
        end
    endtask : axr
    // Responses are judged where they appear, against the oldest note
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            if (exp_b.size() == 0) num_errors++;
            else cmp({30'h0, s_axi_bresp}, {30'h0, exp_b.pop_front()});
        end
        if (s_axi_rvalid && s_axi_rready) begin
            if (exp_rr.size() == 0) num_errors++;
            else begin
                cmp({30'h0, s_axi_rresp}, {30'h0, exp_rr.pop_front()});
                cmp(s_axi_rdata & exp_rm.pop_front(), exp_rd.pop_front());
            end
        end
    end
    initial begin
        logic [2:0] r;
        void'($urandom(8679));
        tick(8);
        aresetn <= 1;
        power_up_evt <= 1;
        tick(1);
        power_up_evt <= 0;
        tick(2);
        cmp(bor_level_sel, 32'h2);
        axr(`BPD_OFS_BO_CFG, 32'h2, 32'h7, `BPD_RESP_OKAY);
        axr(`BPD_OFS_USER_CFG1, 32'h10, 32'h38, `BPD_RESP_OKAY);
        axr(`BPD_OFS_RST_SRC, 32'h10, 32'h70, `BPD_RESP_OKAY);
        axr(12'h020, 32'h0, 32'hffffffff, `BPD_RESP_SLVERR);
        axw(`BPD_OFS_STATUS, 32'h0, `BPD_RESP_SLVERR);
        // Bus reset in mid-run must leave the power-on flag alone
        aresetn <= 0;
        tick(2);
        aresetn <= 1;
        tick(2);
        axr(`BPD_OFS_RST_SRC, 32'h10, 32'h70, `BPD_RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            r = 3'($urandom_range(7));
            axw(`BPD_OFS_USER_CFG1, 32'(i) << 3, `BPD_RESP_OKAY);
            axw(`BPD_OFS_BO_CFG, {29'h0, r}, `BPD_RESP_OKAY);
            tick(2);
            cmp(bor_level_sel, 32'(i));
            cmp(bo_irq_level_sel, {29'h0, r});
        end
        // Reset level below the warning level
        axw(`BPD_OFS_USER_CFG1, 32'h10, `BPD_RESP_OKAY);
        axw(`BPD_OFS_BO_CFG, 32'h3, `BPD_RESP_OKAY);
        for (int m = 0; m < 4; m++) begin
            axw(`BPD_OFS_PWR_CTRL, 32'h10 | 32'(m), `BPD_RESP_OKAY);
            tick(3);
            cmp(bor_en, 32'(m < 2));
            cmp(boi_en, 32'(m < 2));
            cmp(fl_en, 32'(m < 2));
        end
        axw(`BPD_OFS_PWR_CTRL, 32'h0, `BPD_RESP_OKAY);
        tick(3);
        cmp(boi_en, 32'h0);
        axw(`BPD_OFS_PWR_CTRL, 32'h10, `BPD_RESP_OKAY);
        axw(`BPD_OFS_RST_SRC, 32'h10, `BPD_RESP_OKAY);
        setv(2200);
        cmp(chip_reset, 32'h1);
        setv(2300);
        cmp(chip_reset, 32'h1);
        setv(3300);
        cmp(chip_reset, 32'h0);
        axr(`BPD_OFS_RST_SRC, 32'h70, 32'h70, `BPD_RESP_OKAY);
        axw(`BPD_OFS_RST_SRC, 32'h10, `BPD_RESP_OKAY);
        axr(`BPD_OFS_RST_SRC, 32'h10, 32'h70, `BPD_RESP_OKAY);
        setv(2800);
        cmp(brownout_irq, 32'h0);
        axw(`BPD_OFS_IRQ_EN0, 32'h20, `BPD_RESP_OKAY);
        tick(3);
        cmp(brownout_irq, 32'h0);
        axw(`BPD_OFS_IRQ_EN0, 32'ha0, `BPD_RESP_OKAY);
        tick(3);
        cmp(brownout_irq, 32'h1);
        cmp(chip_reset, 32'h0);
        axr(`BPD_OFS_RST_SRC, 32'h50, 32'h70, `BPD_RESP_OKAY);
        setv(3300);
        axw(`BPD_OFS_RST_SRC, 32'h0, `BPD_RESP_OKAY);
        tick(3);
        cmp(brownout_irq, 32'h0);
        axw(`BPD_OFS_PWR_CTRL, 32'h12, `BPD_RESP_OKAY);
        setv(2000);
        cmp(chip_reset, 32'h0);
        cmp(brownout_irq, 32'h0);
        setv(3300);
        axw(`BPD_OFS_PWR_CTRL, 32'h10, `BPD_RESP_OKAY);
        axr(`BPD_OFS_RST_SRC, 32'h0, 32'h70, `BPD_RESP_OKAY);
        flash_op_req <= 1;
        setv(2300);
        cmp({blocked, grant}, 32'h2);
        axr(`BPD_OFS_STATUS, 32'h1b, 32'h1f, `BPD_RESP_OKAY);
        setv(3300);
        cmp({blocked, grant}, 32'h1);
        tick(4);
        print_verdict();
    end
endmodule : testbench

// ---- src/bpd_ctrl.sv ----
// Brownout and power-on detect control with AXI4-Lite register access
//
// Contract
// - Power-mode bits decode as 00 normal, 01 idle, 10 power-down, 11 total power-down.
// - In modes 10 and 11 all brownout circuitry is off, so no brownout reset or interrupt.
// - In normal or idle mode brownout reset and flash protection stay on, not software-gated.
// - Brownout interrupt detection is enabled only while power control bit 4 is set.
// - A brownout interrupt is delivered in normal/idle only with detect, source and global enables.
// - The reset trip level comes from config byte 1 bits 5:3; 000 and 001 are reserved.
// - The interrupt trip level comes from brownout config bits 2:0; 000 and 001 are reserved.
// - The brownout reset flag resets to 0 and sets whenever the brownout reset trips.
// - The brownout interrupt flag resets to 0 and sets whenever the interrupt detector trips.
// - Flash protection is active except when power-mode bit 1 is set.
// - Below the fixed flash level every flash program and erase is blocked while power-mode bit 1 is clear.
// - A brownout asserts below the falling level and, while its detector is enabled, negates only above the rising level.
// - The power-on flag sets on initial power-up.
// - The power-on flag stays set until software clears it.
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`include "bpd_params.svh"
module bpd_ctrl
    import bpd_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        power_up_evt,
    input  wire logic        bor_below_fall,
    input  wire logic        bor_above_rise,
    input  wire logic        boi_below_fall,
    input  wire logic        boi_above_rise,
    input  wire logic        flash_below_trip,
    input  wire logic        flash_op_req,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [2:0]       bor_level_sel,
    output logic [2:0]       bo_irq_level_sel,
    output logic             bor_detector_en,
    output logic             boi_detector_en,
    output logic             flash_detector_en,
    output logic             chip_reset,
    output logic             brownout_irq,
    output logic             flash_op_grant,
    output logic             flash_op_blocked
);
    import bpd_pkg::*;

    // Register state
    logic [7:0]     power_control_reg;
    logic [7:0]     irq_enable_reg0;
    logic [7:0]     brownout_cfg_reg;
    logic [7:0]     user_config_byte1;
    logic [7:0]     next_power_control_reg;
    logic [7:0]     next_irq_enable_reg0;
    logic [7:0]     next_brownout_cfg_reg;
    logic [7:0]     next_user_config_byte1;
    // Detector state
    logic           bor_cond;
    logic           boi_cond;
    logic           next_bor_cond;
    logic           next_boi_cond;
    bpd_rst_state_t rst_state;
    bpd_rst_state_t next_rst_state;
    // Bus state
    logic           aw_held;
    logic           w_held;
    logic [11:0]    aw_addr;
    logic [31:0]    w_data;
    logic [3:0]     w_strb;
    logic           next_aw_held;
    logic           next_w_held;
    logic [11:0]    next_aw_addr;
    logic [31:0]    next_w_data;
    logic [3:0]     next_w_strb;
    logic           next_bvalid;
    logic [1:0]     next_bresp;
    logic           next_rvalid;
    logic [31:0]    next_rdata;
    logic [1:0]     next_rresp;
    // Decoded terms
    bpd_mode_t      mode;
    logic           detect_on;
    logic           flash_on;
    logic           bor_trip;
    logic           boi_trip;
    logic           wr_fire;
    logic           wr_ok;
    logic           clr_rst_src;
    logic           bor_flag;
    logic           boi_flag;
    logic           por_flag;
    logic [7:0]     rst_src_val;
    logic [7:0]     status_val;

    assign mode      = bpd_mode_t'(power_control_reg[`BPD_PWR_MODE_HI_BIT:`BPD_PWR_MODE_LO_BIT]);
    assign detect_on = (mode == BPD_MODE_NORMAL) || (mode == BPD_MODE_IDLE);
    assign flash_on  = !power_control_reg[`BPD_PWR_MODE_HI_BIT];

    // Hysteresis: while its detector is enabled, only the rising comparator can negate a held condition
    always_comb begin
        next_bor_cond = bor_cond;
        next_boi_cond = boi_cond;
        if (!detect_on) begin
            next_bor_cond = 1'b0;
            next_boi_cond = 1'b0;
        end else begin
            if (bor_below_fall) begin
                next_bor_cond = 1'b1;
            end else if (bor_above_rise) begin
                next_bor_cond = 1'b0;
            end
            if (!power_control_reg[`BPD_BOI_DET_EN_BIT]) begin
                next_boi_cond = 1'b0;
            end else if (boi_below_fall) begin
                next_boi_cond = 1'b1;
            end else if (boi_above_rise) begin
                next_boi_cond = 1'b0;
            end
        end
    end

    assign bor_trip = next_bor_cond && !bor_cond;
    assign boi_trip = next_boi_cond && !boi_cond;

    // Reset is held until the brownout condition negates
    always_comb begin
        next_rst_state = rst_state;
        case (rst_state)
            BPD_RST_IDLE: begin
                if (bor_trip) begin
                    next_rst_state = BPD_RST_HOLD;
                end
            end
            BPD_RST_HOLD: begin
                if (!next_bor_cond) begin
                    next_rst_state = BPD_RST_CLEAR;
                end
            end
            BPD_RST_CLEAR: begin
                next_rst_state = next_bor_cond ? BPD_RST_HOLD : BPD_RST_IDLE;
            end
            default: begin
                next_rst_state = BPD_RST_IDLE;
            end
        endcase
    end

    assign wr_fire     = aw_held && w_held && !s_axi_bvalid;
    assign wr_ok       = (aw_addr[1:0] == 2'b00) && w_strb[0];
    assign clr_rst_src = wr_fire && wr_ok && (aw_addr == `BPD_OFS_RST_SRC);

    bpd_sticky_flag #(.RESET_VALUE(1'b0)) u_bor_flag (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set_evt (bor_trip),
        .clr_req (clr_rst_src && !w_data[`BPD_BOR_FLAG_BIT]),
        .flag    (bor_flag)
    );
    bpd_sticky_flag #(.RESET_VALUE(1'b0)) u_boi_flag (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set_evt (boi_trip),
        .clr_req (clr_rst_src && !w_data[`BPD_BOI_FLAG_BIT]),
        .flag    (boi_flag)
    );
    // Bus reset must not clear it: only power-up sets and only software clears
    bpd_sticky_flag #(.RESET_VALUE(1'b0)) u_por_flag (
        .aclk    (aclk),
        .aresetn (1'b1),
        .set_evt (power_up_evt),
        .clr_req (clr_rst_src && !w_data[`BPD_POR_FLAG_BIT]),
        .flag    (por_flag)
    );

    always_comb begin
        rst_src_val = 8'h00;
        rst_src_val[`BPD_BOR_FLAG_BIT] = bor_flag;
        rst_src_val[`BPD_BOI_FLAG_BIT] = boi_flag;
        rst_src_val[`BPD_POR_FLAG_BIT] = por_flag;
        status_val = {3'h0, flash_below_trip && flash_on, boi_cond, bor_cond, detect_on, flash_on};
    end

    // Register writes; only byte lane 0 carries data
    always_comb begin
        next_power_control_reg = power_control_reg;
        next_irq_enable_reg0   = irq_enable_reg0;
        next_brownout_cfg_reg  = brownout_cfg_reg;
        next_user_config_byte1 = user_config_byte1;
        if (wr_fire && wr_ok) begin
            case (aw_addr)
                `BPD_OFS_PWR_CTRL:  next_power_control_reg = w_data[7:0];
                `BPD_OFS_IRQ_EN0:   next_irq_enable_reg0   = w_data[7:0];
                `BPD_OFS_BO_CFG:    next_brownout_cfg_reg  = w_data[7:0];
                `BPD_OFS_USER_CFG1: next_user_config_byte1 = w_data[7:0];
                default: begin
                end
            endcase
        end
    end

    // AXI4-Lite channel handling; address and data may arrive in either order
    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (wr_ok && (aw_addr <= `BPD_OFS_RST_SRC)) ? `BPD_RESP_OKAY
                                                                    : `BPD_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = `BPD_RESP_OKAY;
            case (s_axi_araddr)
                `BPD_OFS_PWR_CTRL:  next_rdata = {24'h0, power_control_reg};
                `BPD_OFS_IRQ_EN0:   next_rdata = {24'h0, irq_enable_reg0};
                `BPD_OFS_BO_CFG:    next_rdata = {24'h0, brownout_cfg_reg};
                `BPD_OFS_USER_CFG1: next_rdata = {24'h0, user_config_byte1};
                `BPD_OFS_RST_SRC:   next_rdata = {24'h0, rst_src_val};
                `BPD_OFS_STATUS:    next_rdata = {24'h0, status_val};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = `BPD_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_control_reg <= 8'h00;
            irq_enable_reg0   <= 8'h00;
            brownout_cfg_reg  <= `BPD_BO_CFG_RESET;
            user_config_byte1 <= `BPD_USER_CFG1_RESET;
            bor_cond          <= 1'b0;
            boi_cond          <= 1'b0;
            rst_state         <= BPD_RST_IDLE;
            aw_held           <= 1'b0;
            w_held            <= 1'b0;
            aw_addr           <= 12'h000;
            w_data            <= 32'h0000_0000;
            w_strb            <= 4'h0;
            s_axi_bvalid      <= 1'b0;
            s_axi_bresp       <= `BPD_RESP_OKAY;
            s_axi_rvalid      <= 1'b0;
            s_axi_rdata       <= 32'h0000_0000;
            s_axi_rresp       <= `BPD_RESP_OKAY;
            s_axi_awready     <= 1'b0;
            s_axi_wready      <= 1'b0;
            s_axi_arready     <= 1'b0;
        end else begin
            power_control_reg <= next_power_control_reg;
            irq_enable_reg0   <= next_irq_enable_reg0;
            brownout_cfg_reg  <= next_brownout_cfg_reg;
            user_config_byte1 <= next_user_config_byte1;
            bor_cond          <= next_bor_cond;
            boi_cond          <= next_boi_cond;
            rst_state         <= next_rst_state;
            aw_held           <= next_aw_held;
            w_held            <= next_w_held;
            aw_addr           <= next_aw_addr;
            w_data            <= next_w_data;
            w_strb            <= next_w_strb;
            s_axi_bvalid      <= next_bvalid;
            s_axi_bresp       <= next_bresp;
            s_axi_rvalid      <= next_rvalid;
            s_axi_rdata       <= next_rdata;
            s_axi_rresp       <= next_rresp;
            // Ready drops once a beat is held, so one write at a time
            s_axi_awready     <= !next_aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready      <= !next_w_held && !(s_axi_wvalid && s_axi_wready);
            s_axi_arready     <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
        end
    end

    // Outputs registered; reserved level codes pass through, analog holds them at 0 mV and never trips
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bor_level_sel     <= 3'h2;
            bo_irq_level_sel  <= 3'h2;
            bor_detector_en   <= 1'b0;
            boi_detector_en   <= 1'b0;
            flash_detector_en <= 1'b0;
            chip_reset        <= 1'b0;
            brownout_irq      <= 1'b0;
            flash_op_grant    <= 1'b0;
            flash_op_blocked  <= 1'b0;
        end else begin
            bor_level_sel     <= user_config_byte1[`BPD_BOR_LVL_LSB+:3];
            bo_irq_level_sel  <= brownout_cfg_reg[`BPD_BO_LVL_LSB+:3];
            bor_detector_en   <= detect_on;
            boi_detector_en   <= detect_on && power_control_reg[`BPD_BOI_DET_EN_BIT];
            flash_detector_en <= flash_on;
            chip_reset        <= (next_rst_state == BPD_RST_HOLD);
            brownout_irq      <= detect_on && power_control_reg[`BPD_BOI_DET_EN_BIT]
                                 && irq_enable_reg0[`BPD_BOI_SRC_EN_BIT]
                                 && irq_enable_reg0[`BPD_GLB_IRQ_EN_BIT] && boi_flag;
            flash_op_grant    <= flash_op_req && !(flash_on && flash_below_trip);
            flash_op_blocked  <= flash_op_req && flash_on && flash_below_trip;
        end
    end

    property p_no_bo_in_pd;
        @(posedge aclk) disable iff (!aresetn)
        power_control_reg[`BPD_PWR_MODE_HI_BIT] |=> !bor_detector_en && !brownout_irq;
    endproperty
    a_no_bo_in_pd: assert property (p_no_bo_in_pd) else $error("brownout active in power-down");

    property p_bor_on_run;
        @(posedge aclk) disable iff (!aresetn)
        // Attempt launched at the release edge sees outputs already loaded by the first non-reset update
        aresetn && !power_control_reg[`BPD_PWR_MODE_HI_BIT]
            |=> bor_detector_en && flash_detector_en;
    endproperty
    a_bor_on_run: assert property (p_bor_on_run) else $error("detector off in run mode");

    property p_irq_gate;
        @(posedge aclk) disable iff (!aresetn)
        brownout_irq |-> $past(irq_enable_reg0[`BPD_GLB_IRQ_EN_BIT])
                         && $past(irq_enable_reg0[`BPD_BOI_SRC_EN_BIT]) && $past(boi_flag);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");

    property p_boi_det;
        @(posedge aclk) disable iff (!aresetn)
        !power_control_reg[`BPD_BOI_DET_EN_BIT] |=> !boi_cond && !boi_detector_en;
    endproperty
    a_boi_det: assert property (p_boi_det) else $error("irq detect while disabled");

    property p_bor_flag_set;
        @(posedge aclk) disable iff (!aresetn)
        $rose(bor_cond) |-> bor_flag;
    endproperty
    a_bor_flag_set: assert property (p_bor_flag_set) else $error("reset flag not set");

    property p_boi_flag_set;
        @(posedge aclk) disable iff (!aresetn)
        $rose(boi_cond) |-> boi_flag;
    endproperty
    a_boi_flag_set: assert property (p_boi_flag_set) else $error("irq flag not set");

    property p_hyst;
        @(posedge aclk) disable iff (!aresetn)
        bor_cond && detect_on && !bor_above_rise |=> bor_cond;
    endproperty
    a_hyst: assert property (p_hyst) else $error("brownout negated early");

    property p_flash_block;
        @(posedge aclk) disable iff (!aresetn)
        flash_op_req && flash_below_trip && flash_on |=> flash_op_blocked && !flash_op_grant;
    endproperty
    a_flash_block: assert property (p_flash_block) else $error("flash op not blocked");

    property p_rst_hold;
        @(posedge aclk) disable iff (!aresetn)
        bor_cond |-> chip_reset;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("chip reset not held");

    property p_por_sticky;
        @(posedge aclk) disable iff (!aresetn)
        por_flag && !clr_rst_src |=> por_flag;
    endproperty
    a_por_sticky: assert property (p_por_sticky) else $error("power-on flag lost");
endmodule : bpd_ctrl

// ---- src/bpd_sticky_flag.sv ----
// Sticky status flag: hardware set beats software clear
module bpd_sticky_flag #(
    parameter logic RESET_VALUE = 1'b0
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic set_evt,
    input  wire logic clr_req,
    output logic      flag
);
    logic next_flag;

    always_comb begin
        next_flag = flag;
        if (clr_req) begin
            next_flag = 1'b0;
        end
        if (set_evt) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag <= RESET_VALUE;
        end else begin
            flag <= next_flag;
        end
    end
endmodule : bpd_sticky_flag
